// File: lpm_params.svh
// Constants for the low-power mode controller
// Overview of operation
// - With DC-DC control bit 0 the converter is unpowered in low power
// - Supply bits act only in standby or deep-sleep, never while active
// - Settings act only after copy into always-on register; auto copy when set
// - Bit 14 opens or closes the DC-DC bypass in standby or deep-sleep
// - Bits 13 and 12 switch DC-DC outputs one and two in standby or deep-sleep
// - Writing bit 9 requests light-sleep
// - Writing bit 8 requests deep-sleep, or standby when standby is selected
// - In auto mode hardware drives bits 23 to 21 and 18 to 15
// - Bit 6 gates the slow clock: 1 runs, 0 stops
// - In low power only the core clock is gated; the slow clock follows bit 6
// - Deep-sleep request with standby select 1 enters standby
// - Deep-sleep request with standby select 0 enters deep-sleep
// - Bit 3 enables the wake counter
// - Bit 2 enables low-power sleep operation
// - Bit 1 picks wake pin level: 1 high, 0 low
// - Bit 0 enables the wake pin as wake source
// - Wake interval is a 32-bit register resetting to zero
// - One wake interval unit is 31.2 us
// - Wake flags for counter, pin, sleep, standby; write 1 clears
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
`define LPM_OFS_SYNC 5'h00
`define LPM_OFS_FLOW 5'h04
`define LPM_OFS_INTERVAL 5'h08
`define LPM_OFS_FLAGS 5'h0c
`define LPM_SYNC_AUTO 0
`define LPM_SYNC_NOW 1
`define LPM_SYNC_STATE_LO 4
`define LPM_FLOW_SUPPLY_LO 12
`define LPM_FLOW_LIGHT_REQ 9
`define LPM_FLOW_DEEP_REQ 8
`define LPM_FLOW_MANUAL 7
`define LPM_FLOW_SLOW_CLK 6
`define LPM_FLOW_STANDBY_SEL 4
`define LPM_FLOW_CNT_EN 3
`define LPM_FLOW_SLEEP_EN 2
`define LPM_FLOW_PIN_LEVEL 1
`define LPM_FLOW_PIN_EN 0
`define LPM_FLAG_TIMER 17
`define LPM_FLAG_PIN 16
`define LPM_FLAG_SLEEP 9
`define LPM_FLAG_STANDBY 8
`define LPM_FLOW_RESET 32'h0000_0000
`define LPM_INTERVAL_RESET 32'h0000_0000
`define LPM_SUPPLY_ACTIVE 20'hffffb
`define LPM_SUPPLY_HW_MASK 20'h00e78
`define LPM_STEP_US 31.2
`define LPM_CLK_MHZ 125
`define LPM_STEP_CYC ($rtoi(`LPM_STEP_US * `LPM_CLK_MHZ))
`endif

// File: lpm_pkg.sv
// Types shared by the low-power mode controller
package lpm_pkg;
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_LIGHT = 2'b01,
		ST_DEEP = 2'b10,
		ST_STANDBY = 2'b11
	} lp_state_t;
	typedef struct packed {
		logic [19:0] supply;
		logic coreClockOn;
		logic slowClockOn;
	} power_out_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avmm_req_t;
endpackage

// File: lpm_wake_timer.sv
// Wake interval counter in fixed time steps
`timescale 1ns/1ps
`include "lpm_params.svh"
module lpm_wake_timer #(
	parameter int STEP_CYCLES = `LPM_STEP_CYC,
	parameter int WIDTH = 32
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [WIDTH-1:0] interval,
	output logic wakePulse
);
	localparam int PW = $clog2(STEP_CYCLES);
	logic [PW-1:0] prescale;
	logic [WIDTH-1:0] steps;
	logic tick;
	assign tick = run && (prescale == PW'(STEP_CYCLES - 1));
	always_ff @(posedge mclk) begin
		if (sys_rst || !run) begin
			prescale <= '0;
		end else if (tick) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + PW'(1);
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst || !run) begin
			steps <= '0;
		end else if (tick) begin
			steps <= steps + WIDTH'(1);
		end
	end
	// Interval zero fires at the first step, so a stuck sleeper never results
	always_ff @(posedge mclk) begin
		if (sys_rst || !run) begin
			wakePulse <= 1'b0;
		end else begin
			wakePulse <= tick && ((steps + WIDTH'(1)) >= interval);
		end
	end
	property p_tick_spacing;
		@(posedge mclk) disable iff (sys_rst) tick |-> $past(run) && prescale != '0;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("step tick too early");
	property p_fire_needs_step;
		@(posedge mclk) disable iff (sys_rst) $rose(wakePulse) |-> $past(tick) && $past(run);
	endproperty
	a_fire_needs_step: assert property (p_fire_needs_step) else $error("wake without step");
endmodule

// File: low_power_mode_control.sv
// Low-power mode controller with Avalon-MM register access
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "lpm_params.svh"
module low_power_mode_control #(
	parameter int STEP_CYCLES = `LPM_STEP_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire lpm_pkg::avmm_req_t avReq,
	output logic avWaitrequest,
	output logic [31:0] avReaddata,
	input wire logic wakePin,
	output lpm_pkg::power_out_t powerOut,
	output lpm_pkg::lp_state_t powerState
);
	import lpm_pkg::*;

	logic [31:0] flowReg;
	logic [31:0] intervalReg;
	logic syncAuto;
	logic syncPulse;
	logic [31:0] aoFlow;
	logic [31:0] aoInterval;
	logic [3:0] flags;
	lp_state_t state;
	lp_state_t next_state;
	logic pinS1;
	logic pinS2;
	logic pinS3;
	logic pinLevel;
	logic timerRun;
	logic timerWake;
	logic pinWake;
	logic wakeTaken;
	logic enterLp;
	logic accept;
	logic wrTaken;
	logic syncNow;

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isLowSupplyState(input lp_state_t s);
		return (s == ST_DEEP) || (s == ST_STANDBY);
	endfunction

	// Bus slave: waitrequest drops one cycle after a request appears
	assign accept = (avReq.read || avReq.write) && !avWaitrequest;
	assign wrTaken = accept && avReq.write;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avWaitrequest <= 1'b1;
		end else if ((avReq.read || avReq.write) && avWaitrequest) begin
			avWaitrequest <= 1'b0;
		end else begin
			avWaitrequest <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avReaddata <= 32'h0000_0000;
		end else if (avReq.read && avWaitrequest) begin
			if (avReq.address == `LPM_OFS_SYNC) begin
				avReaddata <= {26'h0, state, 3'h0, syncAuto};
			end else if (avReq.address == `LPM_OFS_FLOW) begin
				avReaddata <= flowReg;
			end else if (avReq.address == `LPM_OFS_INTERVAL) begin
				avReaddata <= intervalReg;
			end else if (avReq.address == `LPM_OFS_FLAGS) begin
				avReaddata <= {14'h0, flags[3:2], 6'h0, flags[1:0], 8'h0};
			end else begin
				avReaddata <= 32'h0000_0000;
			end
		end
	end

	// Sync control: auto copy flag, plus a one-shot copy strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			syncAuto <= 1'b0;
		end else if (wrTaken && avReq.address == `LPM_OFS_SYNC && avReq.byteenable[0]) begin
			syncAuto <= avReq.writedata[`LPM_SYNC_AUTO];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			syncPulse <= 1'b0;
		end else begin
			syncPulse <= wrTaken && avReq.address == `LPM_OFS_SYNC && avReq.byteenable[0]
				&& avReq.writedata[`LPM_SYNC_NOW];
		end
	end

	assign syncNow = syncAuto || syncPulse;

	// Request bits are consumed on entry; a new write of 1 wins over that clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flowReg <= `LPM_FLOW_RESET;
		end else if (wrTaken && avReq.address == `LPM_OFS_FLOW) begin
			flowReg <= mergeBytes(flowReg, avReq.writedata, avReq.byteenable);
		end else if (enterLp) begin
			flowReg[`LPM_FLOW_LIGHT_REQ] <= 1'b0;
			flowReg[`LPM_FLOW_DEEP_REQ] <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			intervalReg <= `LPM_INTERVAL_RESET;
		end else if (wrTaken && avReq.address == `LPM_OFS_INTERVAL) begin
			intervalReg <= mergeBytes(intervalReg, avReq.writedata, avReq.byteenable);
		end
	end

	// Always-on copy; nothing downstream looks at the bus-side registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			aoFlow <= `LPM_FLOW_RESET;
		end else if (enterLp) begin
			aoFlow[`LPM_FLOW_LIGHT_REQ] <= 1'b0;
			aoFlow[`LPM_FLOW_DEEP_REQ] <= 1'b0;
		end else if (syncNow) begin
			aoFlow <= flowReg;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			aoInterval <= `LPM_INTERVAL_RESET;
		end else if (syncNow) begin
			aoInterval <= intervalReg;
		end
	end

	// Wake pin: three stages, a level change counts once stages two and three agree
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pinS1 <= 1'b0;
			pinS2 <= 1'b0;
			pinS3 <= 1'b0;
		end else begin
			pinS1 <= wakePin;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pinLevel <= 1'b0;
		end else if (pinS2 == pinS3) begin
			pinLevel <= pinS3;
		end
	end

	// Timer needs the slow clock, so gating it off also stops the wake counter
	assign timerRun = (state != ST_ACTIVE) && aoFlow[`LPM_FLOW_CNT_EN]
		&& aoFlow[`LPM_FLOW_SLOW_CLK];

	lpm_wake_timer #(
		.STEP_CYCLES(STEP_CYCLES),
		.WIDTH(32)
	) u_wake_timer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.run(timerRun),
		.interval(aoInterval),
		.wakePulse(timerWake)
	);

	assign pinWake = aoFlow[`LPM_FLOW_PIN_EN]
		&& (pinLevel == aoFlow[`LPM_FLOW_PIN_LEVEL]);
	assign wakeTaken = (state != ST_ACTIVE) && (timerWake || pinWake);
	assign enterLp = (state == ST_ACTIVE) && (next_state != ST_ACTIVE);

	// Deep request outranks light request when both are pending
	always_comb begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (aoFlow[`LPM_FLOW_SLEEP_EN]) begin
					if (aoFlow[`LPM_FLOW_DEEP_REQ]) begin
						if (aoFlow[`LPM_FLOW_STANDBY_SEL]) begin
							next_state = ST_STANDBY;
						end else begin
							next_state = ST_DEEP;
						end
					end else if (aoFlow[`LPM_FLOW_LIGHT_REQ]) begin
						next_state = ST_LIGHT;
					end
				end
			end
			default: begin
				if (timerWake || pinWake) begin
					next_state = ST_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	// Flags: wake set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flags <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				flags[i] <= (flags[i] && !(wrTaken && avReq.address == `LPM_OFS_FLAGS
					&& avReq.writedata[i < 2 ? 8 + i : 14 + i]))
					|| (wakeTaken && (i == 3 ? timerWake : i == 2 ? (pinWake && !timerWake)
					: i == 1 ? (state == ST_DEEP || state == ST_LIGHT)
					: state == ST_STANDBY));
			end
		end
	end

	// Outputs: supplies follow software only while in standby or deep-sleep
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			powerOut.supply <= `LPM_SUPPLY_ACTIVE;
		end else if (isLowSupplyState(state)) begin
			if (aoFlow[`LPM_FLOW_MANUAL]) begin
				powerOut.supply <= aoFlow[31:`LPM_FLOW_SUPPLY_LO];
			end else begin
				powerOut.supply <= aoFlow[31:`LPM_FLOW_SUPPLY_LO]
					& ~`LPM_SUPPLY_HW_MASK;
			end
		end else begin
			powerOut.supply <= `LPM_SUPPLY_ACTIVE;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			powerOut.coreClockOn <= 1'b1;
		end else begin
			powerOut.coreClockOn <= (state == ST_ACTIVE);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			powerOut.slowClockOn <= 1'b0;
		end else begin
			powerOut.slowClockOn <= aoFlow[`LPM_FLOW_SLOW_CLK];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			powerState <= ST_ACTIVE;
		end else begin
			powerState <= next_state;
		end
	end

	property p_core_gate;
		@(posedge mclk) disable iff (sys_rst) state != ST_ACTIVE |=> !powerOut.coreClockOn;
	endproperty
	a_core_gate: assert property (p_core_gate) else $error("core clock not gated");

	property p_slow_gate;
		@(posedge mclk) disable iff (sys_rst)
			##1 powerOut.slowClockOn == $past(aoFlow[`LPM_FLOW_SLOW_CLK]);
	endproperty
	a_slow_gate: assert property (p_slow_gate) else $error("slow clock gate wrong");

	property p_light_entry;
		@(posedge mclk) disable iff (sys_rst) state == ST_ACTIVE && aoFlow[`LPM_FLOW_SLEEP_EN]
			&& aoFlow[`LPM_FLOW_LIGHT_REQ] && !aoFlow[`LPM_FLOW_DEEP_REQ] |=> state == ST_LIGHT;
	endproperty
	a_light_entry: assert property (p_light_entry) else $error("no light-sleep entry");

	property p_standby_entry;
		@(posedge mclk) disable iff (sys_rst) state == ST_ACTIVE && aoFlow[`LPM_FLOW_SLEEP_EN]
			&& aoFlow[`LPM_FLOW_DEEP_REQ] && aoFlow[`LPM_FLOW_STANDBY_SEL] |=> state == ST_STANDBY;
	endproperty
	a_standby_entry: assert property (p_standby_entry) else $error("no standby entry");

	property p_deep_entry;
		@(posedge mclk) disable iff (sys_rst) state == ST_ACTIVE && aoFlow[`LPM_FLOW_SLEEP_EN]
			&& aoFlow[`LPM_FLOW_DEEP_REQ] && !aoFlow[`LPM_FLOW_STANDBY_SEL] |=> state == ST_DEEP;
	endproperty
	a_deep_entry: assert property (p_deep_entry) else $error("no deep-sleep entry");

	property p_sleep_disabled;
		@(posedge mclk) disable iff (sys_rst)
			state == ST_ACTIVE && !aoFlow[`LPM_FLOW_SLEEP_EN] |=> state == ST_ACTIVE;
	endproperty
	a_sleep_disabled: assert property (p_sleep_disabled) else $error("slept while disabled");

	property p_active_supply;
		@(posedge mclk) disable iff (sys_rst)
			!isLowSupplyState(state) |=> powerOut.supply == `LPM_SUPPLY_ACTIVE;
	endproperty
	a_active_supply: assert property (p_active_supply) else $error("supply moved in active");

	property p_switch_bits;
		@(posedge mclk) disable iff (sys_rst)
			isLowSupplyState(state) |=> powerOut.supply[2:0] == $past(aoFlow[14:12]);
	endproperty
	a_switch_bits: assert property (p_switch_bits) else $error("bypass or output wrong");

	property p_manual_dcdc;
		@(posedge mclk) disable iff (sys_rst) isLowSupplyState(state) && aoFlow[`LPM_FLOW_MANUAL]
			|=> powerOut.supply[3] == $past(aoFlow[15]);
	endproperty
	a_manual_dcdc: assert property (p_manual_dcdc) else $error("DC-DC enable wrong");

	property p_auto_hw;
		@(posedge mclk) disable iff (sys_rst) isLowSupplyState(state) && !aoFlow[`LPM_FLOW_MANUAL]
			|=> (powerOut.supply & `LPM_SUPPLY_HW_MASK) == 20'h00000;
	endproperty
	a_auto_hw: assert property (p_auto_hw) else $error("auto supply bits wrong");

	property p_no_sync_hold;
		@(posedge mclk) disable iff (sys_rst) !syncNow && !enterLp |=> $stable(aoFlow);
	endproperty
	a_no_sync_hold: assert property (p_no_sync_hold) else $error("copy without sync");

	property p_pin_wake;
		@(posedge mclk) disable iff (sys_rst) state != ST_ACTIVE && pinWake
			|=> state == ST_ACTIVE && (flags[2] || flags[3]);
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin did not wake");

	property p_counter_off;
		@(posedge mclk) disable iff (sys_rst) !aoFlow[`LPM_FLOW_CNT_EN] |-> !timerRun;
	endproperty
	a_counter_off: assert property (p_counter_off) else $error("counter ran disabled");

	property p_interval_reset;
		@(posedge mclk) sys_rst |=> intervalReg == 32'h0000_0000;
	endproperty
	a_interval_reset: assert property (p_interval_reset) else $error("interval reset wrong");

	property p_flag_clear;
		@(posedge mclk) disable iff (sys_rst) wrTaken && avReq.address == `LPM_OFS_FLAGS
			&& avReq.writedata[`LPM_FLAG_TIMER] && !wakeTaken |=> !flags[3];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	c_light: cover property (@(posedge mclk) disable iff (sys_rst) state == ST_LIGHT);
	c_standby: cover property (@(posedge mclk) disable iff (sys_rst) state == ST_STANDBY);
	c_timer_wake: cover property (@(posedge mclk) disable iff (sys_rst) wakeTaken && timerWake);
	c_pin_wake: cover property (@(posedge mclk) disable iff (sys_rst) wakeTaken && pinWake);
endmodule

// File: testbench.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`include "lpm_params.svh"
module testbench;
	import lpm_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	avmm_req_t avReq = '0;
	logic wakePin = 1'b0;
	logic avWaitrequest;
	logic [31:0] avReaddata;
	power_out_t powerOut;
	lp_state_t powerState;
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic [31:0] v;
	logic [31:0] d;
	logic [31:0] flow;
	logic [19:0] sup;
	logic [3:0] be;
	lp_state_t sl;
	int iv;

	always #4 mclk = ~mclk;

	// Short step count keeps the timer scenarios brief
	low_power_mode_control #(.STEP_CYCLES(4)) uut (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.avReq(avReq),
		.avWaitrequest(avWaitrequest),
		.avReaddata(avReaddata),
		.wakePin(wakePin),
		.powerOut(powerOut),
		.powerState(powerState)
	);

	function automatic logic [31:0] b(input int n);
		return 32'h0000_0001 << n;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] e);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (e[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds the request until waitrequest is sampled low; bounded in case it never answers
	task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data,
		input logic [3:0] e);
		int n;
		n = 0;
		@(posedge mclk);
		avReq <= '{read: !wr, write: wr, address: addr, writedata: data, byteenable: e};
		do begin
			@(posedge mclk);
			n++;
		end while (avWaitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			failures++;
			$display("wrong value waitrequest expected 0 seen 1");
			report_and_stop();
		end
		rd = avReaddata;
		avReq <= '0;
	endtask

	task automatic wr(input logic [4:0] addr, input logic [31:0] data);
		bus(1'b1, addr, data, 4'hf);
	endtask

	task automatic rdv(input logic [4:0] addr);
		bus(1'b0, addr, 32'h0000_0000, 4'hf);
	endtask

	task automatic wait_state(input lp_state_t s, input int limit);
		int n;
		n = 0;
		while (powerState !== s && n < limit) begin
			@(posedge mclk);
			n++;
		end
		if (n >= limit) begin
			failures++;
			$display("wrong value powerState expected %h seen %h", s, powerState);
			report_and_stop();
		end
	endtask

	initial begin
		void'($urandom(32'hbbe7cdf9));
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check("state", 32'(powerState), 32'(ST_ACTIVE));
		check("supply", 32'(powerOut.supply), 32'(`LPM_SUPPLY_ACTIVE));
		check("slow clock", 32'(powerOut.slowClockOn), 32'h0);
		check("core clock on", 32'(powerOut.coreClockOn), 32'h1);
		rdv(`LPM_OFS_FLOW);
		check("flow reset", rd, `LPM_FLOW_RESET);
		rdv(`LPM_OFS_INTERVAL);
		check("interval reset", rd, `LPM_INTERVAL_RESET);
		wr(5'h10, 32'hffff_ffff);
		rdv(5'h10);
		check("unmapped", rd, 32'h0);
		$display("test reset done");
		v = 32'h0;
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			be = (i == 0) ? 4'hf : 4'($urandom_range(15, 1));
			v = merge(v, d, be);
			bus(1'b1, `LPM_OFS_INTERVAL, d, be);
			rdv(`LPM_OFS_INTERVAL);
			check("interval", rd, v);
		end
		$display("test interval done");
		// Sleep disabled: a request is ignored and supplies stay at the active value
		wr(`LPM_OFS_SYNC, 32'h1);
		flow = {20'($urandom), 12'h000} | b(`LPM_FLOW_DEEP_REQ) | b(`LPM_FLOW_MANUAL);
		wr(`LPM_OFS_FLOW, flow);
		repeat (6) @(posedge mclk);
		check("no sleep", 32'(powerState), 32'(ST_ACTIVE));
		check("active supply", 32'(powerOut.supply), 32'(`LPM_SUPPLY_ACTIVE));
		wr(`LPM_OFS_SYNC, 32'h0);
		wr(`LPM_OFS_FLOW, 32'h0);
		$display("test sleep disable done");
		// Light sleep needs an explicit copy when auto copy is off, then pin wake at each level
		for (int lvl = 0; lvl < 2; lvl++) begin
			wakePin <= !lvl[0];
			flow = b(`LPM_FLOW_SLEEP_EN) | b(`LPM_FLOW_LIGHT_REQ) | b(`LPM_FLOW_PIN_EN);
			flow = flow | (lvl[0] ? b(`LPM_FLOW_PIN_LEVEL) : 32'h0);
			wr(`LPM_OFS_FLOW, flow);
			repeat (6) @(posedge mclk);
			check("before copy", 32'(powerState), 32'(ST_ACTIVE));
			wr(`LPM_OFS_SYNC, 32'h2);
			wait_state(ST_LIGHT, 10);
			check("light", 32'(powerState), 32'(ST_LIGHT));
			repeat (2) @(posedge mclk);
			check("light supply", 32'(powerOut.supply), 32'(`LPM_SUPPLY_ACTIVE));
			check("core clock", 32'(powerOut.coreClockOn), 32'h0);
			rdv(`LPM_OFS_FLOW);
			check("req cleared", rd, flow & ~b(`LPM_FLOW_LIGHT_REQ));
			check("still asleep", 32'(powerState), 32'(ST_LIGHT));
			wakePin <= lvl[0];
			wait_state(ST_ACTIVE, 12);
			rdv(`LPM_OFS_FLAGS);
			check("pin flags", rd, b(`LPM_FLAG_PIN) | b(`LPM_FLAG_SLEEP));
			wr(`LPM_OFS_FLAGS, rd);
			rdv(`LPM_OFS_FLAGS);
			check("flags clear", rd, 32'h0);
		end
		$display("test light sleep done");
		// Auto copy; deep or standby, manual or auto supplies, timer wake with pin disabled
		wr(`LPM_OFS_SYNC, 32'h1);
		for (int k = 0; k < 4; k++) begin
			iv = 3 + k;
			sl = k[0] ? ST_STANDBY : ST_DEEP;
			sup = 20'($urandom);
			wr(`LPM_OFS_INTERVAL, 32'(iv));
			flow = {sup, 12'h000} | b(`LPM_FLOW_SLEEP_EN) | b(`LPM_FLOW_CNT_EN);
			flow = flow | b(`LPM_FLOW_SLOW_CLK) | b(`LPM_FLOW_DEEP_REQ) | b(`LPM_FLOW_PIN_LEVEL);
			flow = flow | (k[0] ? b(`LPM_FLOW_STANDBY_SEL) : 32'h0);
			flow = flow | (k[1] ? b(`LPM_FLOW_MANUAL) : 32'h0);
			wakePin <= 1'b1;
			wr(`LPM_OFS_FLOW, flow);
			wait_state(sl, 10);
			check("deep kind", 32'(powerState), 32'(sl));
			repeat (2) @(posedge mclk);
			d = 32'(k[1] ? sup : sup & ~`LPM_SUPPLY_HW_MASK);
			check("sleep supply", 32'(powerOut.supply), d);
			check("slow clock on", 32'(powerOut.slowClockOn), 32'h1);
			check("core clock off", 32'(powerOut.coreClockOn), 32'h0);
			repeat (4 * iv - 5) @(posedge mclk);
			check("counting", 32'(powerState), 32'(sl));
			wait_state(ST_ACTIVE, 12);
			check("timer wake", 32'(powerState), 32'(ST_ACTIVE));
			rdv(`LPM_OFS_FLAGS);
			d = b(`LPM_FLAG_TIMER) | (k[0] ? b(`LPM_FLAG_STANDBY) : b(`LPM_FLAG_SLEEP));
			check("timer flags", rd, d);
			wr(`LPM_OFS_FLAGS, rd);
			wakePin <= 1'b0;
		end
		$display("test deep and standby done");
		// Counter stopped by a gated slow clock or by its enable; the pin must end the sleep
		wr(`LPM_OFS_INTERVAL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			flow = b(`LPM_FLOW_SLEEP_EN) | b(`LPM_FLOW_DEEP_REQ) | b(`LPM_FLOW_PIN_EN);
			flow = flow | b(`LPM_FLOW_PIN_LEVEL);
			flow = flow | (k == 0 ? b(`LPM_FLOW_CNT_EN) : b(`LPM_FLOW_SLOW_CLK));
			wr(`LPM_OFS_FLOW, flow);
			wait_state(ST_DEEP, 10);
			repeat (20) @(posedge mclk);
			check("no timer", 32'(powerState), 32'(ST_DEEP));
			check("slow clock gate", 32'(powerOut.slowClockOn), 32'(k));
			wakePin <= 1'b1;
			wait_state(ST_ACTIVE, 12);
			wakePin <= 1'b0;
			rdv(`LPM_OFS_FLAGS);
			check("pin only", rd, b(`LPM_FLAG_PIN) | b(`LPM_FLAG_SLEEP));
			wr(`LPM_OFS_FLAGS, rd);
		end
		$display("test clock gate done");
		// Deep outranks light; then a reset while asleep must restore the state and every power output
		flow = b(`LPM_FLOW_SLEEP_EN) | b(`LPM_FLOW_DEEP_REQ) | b(`LPM_FLOW_LIGHT_REQ);
		wr(`LPM_OFS_FLOW, flow | b(`LPM_FLOW_SLOW_CLK));
		wait_state(ST_DEEP, 10);
		check("deep over light", 32'(powerState), 32'(ST_DEEP));
		rdv(`LPM_OFS_SYNC);
		check("sync reg", rd, {26'h0, ST_DEEP, 4'h1});
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check("reset state", 32'(powerState), 32'(ST_ACTIVE));
		check("reset supply", 32'(powerOut.supply), 32'(`LPM_SUPPLY_ACTIVE));
		check("reset core clock", 32'(powerOut.coreClockOn), 32'h1);
		check("reset slow clock", 32'(powerOut.slowClockOn), 32'h0);
		rdv(`LPM_OFS_INTERVAL);
		check("reset interval", rd, `LPM_INTERVAL_RESET);
		$display("test mid-run reset done");
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		$display("wrong value run length expected end seen timeout");
		report_and_stop();
	end
endmodule
